// ===== hdl/bvsc_top.sv
// Buck mode, spread spectrum and voltage setpoint control
`timescale 1ns/1ps
`include "bvsc_regs.svh"

module bvsc_top #(
    parameter int          PHASES      = 4,
    parameter int          DELAY_CYC   = `BVSC_DELAY_CYC,
    parameter bvsc_pkg::bvsc_code_t NVM_DEFAULT = 8'h41
) (
    input  wire logic                  clock_in,
    input  wire logic                  arst_n_in,
    input  wire logic                  heavy_load_in,
    input  wire logic                  forced_pwm_select_in,
    input  wire logic                  forced_multiphase_select_in,
    input  wire logic [PHASES-1:0]     phase_request_in,
    input  wire logic [1:0]            nvm_ss_source_in,
    input  wire logic                  nvm_valid_in,
    input  wire logic                  ss_enable_in,
    input  wire logic [1:0]            ss_depth_in,
    input  wire logic                  sync_clock_input,
    input  wire logic                  setpoint_a_wr_in,
    input  wire logic                  setpoint_b_wr_in,
    input  wire logic [7:0]            setpoint_wdata_in,
    input  wire logic                  setpoint_choice_in,
    input  wire logic                  fault_recovery_state_in,
    input  wire logic                  warm_reset_in,
    input  wire logic                  low_power_standby_state_in,
    input  wire logic                  skip_standby_reload_in,
    output bvsc_pkg::bvsc_mode_e       mode_out,
    output logic [PHASES-1:0]          phase_active_out,
    output logic [1:0]                 ss_source_out,
    output logic                       ss_active_out,
    output logic [1:0]                 ss_depth_out,
    output logic                       sync_level_out,
    output logic [7:0]                 voltage_setpoint_a_out,
    output logic [7:0]                 voltage_setpoint_b_out,
    output logic [7:0]                 active_code_out,
    output logic [15:0]                active_mv_out,
    output logic [7:0]                 ov_code_out,
    output logic [7:0]                 uv_code_out,
    output logic                       thr_pending_out
);
    // Piecewise-linear code to millivolt conversion
    function automatic bvsc_pkg::bvsc_mv_t code_to_mv(input bvsc_pkg::bvsc_code_t c);
        bvsc_pkg::bvsc_mv_t off;
        off = 16'h0000;
        if (c >= `BVSC_CODE_SEG3) begin
            off = {8'h00, c - `BVSC_CODE_SEG3};
            code_to_mv = 16'(`BVSC_MV_BASE3 + off * `BVSC_MV_STEP3);
        end else if (c >= `BVSC_CODE_SEG2) begin
            off = {8'h00, c - `BVSC_CODE_SEG2};
            code_to_mv = 16'(`BVSC_MV_BASE2 + off * `BVSC_MV_STEP2);
        end else if (c >= `BVSC_CODE_SEG1) begin
            off = {8'h00, c - `BVSC_CODE_SEG1};
            code_to_mv = 16'(`BVSC_MV_BASE1 + off * `BVSC_MV_STEP1);
        end else begin
            off = {8'h00, c};
            code_to_mv = 16'(`BVSC_MV_BASE0 + off * `BVSC_MV_STEP0);
        end
    endfunction

    // Reset level of the millivolt output, kept as a constant for the reset branch
    localparam bvsc_pkg::bvsc_mv_t NVM_DEFAULT_MV = code_to_mv(NVM_DEFAULT);

    logic                 revert;
    logic                 standby_q;
    logic                 standby_entry;
    logic                 src_locked_q;
    logic                 dly_expire;
    logic                 dly_busy;
    logic                 change;
    logic [7:0]           target;
    bvsc_pkg::bvsc_thr_e  thr_q;
    logic                 choice_q;

    bvsc_sync u_sync (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .pin_in    (sync_clock_input),
        .level_out (sync_level_out)
    );

    // Mode: PWM on heavy load, forced PWM, or forced multiphase
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_out <= bvsc_pkg::BVSC_MODE_PWM;
        end else if (heavy_load_in || forced_pwm_select_in || forced_multiphase_select_in) begin
            mode_out <= bvsc_pkg::BVSC_MODE_PWM;
        end else begin
            mode_out <= bvsc_pkg::BVSC_MODE_PFM;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_active_out <= '0;
        end else if (forced_multiphase_select_in) begin
            phase_active_out <= '1;
        end else begin
            phase_active_out <= phase_request_in | PHASES'(1);
        end
    end

    // Source taken once when nonvolatile data turns valid; later changes ignored
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_locked_q  <= 1'b0;
            ss_source_out <= `BVSC_SS_SRC_EXT;
        end else if (nvm_valid_in && !src_locked_q) begin
            src_locked_q  <= 1'b1;
            ss_source_out <= nvm_ss_source_in;
        end
    end

    // Standby state changes never touch spread; only the enable does
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_active_out <= 1'b0;
        end else begin
            ss_active_out <= ss_enable_in;
        end
    end

    // Depth only follows while spread is off, protecting the DPLL from a live change
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_depth_out <= `BVSC_SS_DEPTH_RST;
        end else if (!ss_enable_in && !ss_active_out) begin
            ss_depth_out <= ss_depth_in;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            standby_q <= 1'b0;
        end else begin
            standby_q <= low_power_standby_state_in;
        end
    end

    assign standby_entry = low_power_standby_state_in && !standby_q;
    assign revert = fault_recovery_state_in || warm_reset_in
                    || (standby_entry && !skip_standby_reload_in);

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            voltage_setpoint_a_out <= NVM_DEFAULT;
        end else if (revert) begin
            voltage_setpoint_a_out <= NVM_DEFAULT;
        end else if (setpoint_a_wr_in) begin
            voltage_setpoint_a_out <= setpoint_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            voltage_setpoint_b_out <= NVM_DEFAULT;
        end else if (setpoint_b_wr_in) begin
            voltage_setpoint_b_out <= setpoint_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            choice_q <= 1'b0;
        end else if (revert) begin
            choice_q <= 1'b0;
        end else begin
            choice_q <= setpoint_choice_in;
        end
    end

    // Active level follows only the selected register
    assign target = choice_q ? voltage_setpoint_b_out : voltage_setpoint_a_out;
    assign change = (target != active_code_out);

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            active_code_out <= NVM_DEFAULT;
            active_mv_out   <= NVM_DEFAULT_MV;
        end else if (change) begin
            active_code_out <= target;
            active_mv_out   <= code_to_mv(target);
        end
    end

    bvsc_delay #(
        .CYCLES (DELAY_CYC)
    ) u_delay (
        .clock_in   (clock_in),
        .arst_n_in  (arst_n_in),
        .load_in    (change),
        .abort_in   (1'b0),
        .busy_out   (dly_busy),
        .expire_out (dly_expire)
    );

    // A new change restarts the wait; the lagging threshold only catches up at expiry
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            thr_q       <= bvsc_pkg::BVSC_THR_IDLE;
            ov_code_out <= NVM_DEFAULT;
            uv_code_out <= NVM_DEFAULT;
        end else if (change && target > active_code_out) begin
            thr_q       <= bvsc_pkg::BVSC_THR_UP;
            ov_code_out <= target;
        end else if (change) begin
            thr_q       <= bvsc_pkg::BVSC_THR_DOWN;
            uv_code_out <= target;
        end else if (dly_expire) begin
            thr_q <= bvsc_pkg::BVSC_THR_IDLE;
            case (thr_q)
                bvsc_pkg::BVSC_THR_UP: begin
                    uv_code_out <= active_code_out;
                end
                bvsc_pkg::BVSC_THR_DOWN: begin
                    ov_code_out <= active_code_out;
                end
                default: begin
                    ov_code_out <= active_code_out;
                end
            endcase
        end
    end

    assign thr_pending_out = dly_busy;

    sequence rise_seq;
        change && (target > active_code_out);
    endsequence

    property rise_p;
        @(posedge clock_in) disable iff (!arst_n_in)
        rise_seq |=> (ov_code_out == active_code_out) && (uv_code_out != active_code_out);
    endproperty

    property fall_p;
        @(posedge clock_in) disable iff (!arst_n_in)
        (change && target < active_code_out) |=> (uv_code_out == active_code_out);
    endproperty

    property commit_p;
        @(posedge clock_in) disable iff (!arst_n_in)
        dly_expire |=> (ov_code_out == active_code_out) && (uv_code_out == active_code_out);
    endproperty

    ov_rise_now_a: assert property (rise_p) else $error("OV not moved on rise");
    uv_fall_now_a: assert property (fall_p) else $error("UV not moved on fall");
    thr_commit_a: assert property (commit_p) else $error("Threshold not committed");
    delay_load_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        change |=> dly_busy && !dly_expire) else $error("Delay not loaded");
    pwm_mode_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (heavy_load_in || forced_pwm_select_in) |=> mode_out == bvsc_pkg::BVSC_MODE_PWM)
        else $error("PWM mode not held");
    pfm_mode_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        !(heavy_load_in || forced_pwm_select_in || forced_multiphase_select_in)
        |=> mode_out == bvsc_pkg::BVSC_MODE_PFM) else $error("PFM not entered");
    src_fixed_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $past(src_locked_q) |-> $stable(ss_source_out)) else $error("Source changed");
    ss_follow_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        ss_enable_in |=> ss_active_out) else $error("Spread not active");
    revert_a_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        warm_reset_in |=> voltage_setpoint_a_out == NVM_DEFAULT && !choice_q)
        else $error("Setpoint not reverted");
    multi_all_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        forced_multiphase_select_in |=> &phase_active_out) else $error("Phase shed");
    // A write to B while A stays selected must not reach the active level
    unsel_hold_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (setpoint_b_wr_in && !setpoint_a_wr_in && !choice_q && !setpoint_choice_in
         && !revert && !change) |=> ##1 $stable(active_code_out))
        else $error("Active level moved");
endmodule

// ===== hdl/bvsc_regs.svh
// Constants for the buck voltage select control block
`ifndef BVSC_REGS_SVH
`define BVSC_REGS_SVH

`define BVSC_CLK_MHZ            200
`define BVSC_PWM_LOAD_MA        600
`define BVSC_SS_SRC_EXT         2'h0
`define BVSC_SS_SRC_EXT_DPLL    2'h1
`define BVSC_SS_SRC_RC_DPLL     2'h2
`define BVSC_RC_OSC_MHZ         20
`define BVSC_SS_DEPTH_RST       2'h0
`define BVSC_STARTUP_US         10
`define BVSC_SETTLE_US          20
`define BVSC_BIST_US            30
`define BVSC_DELAY_US           (`BVSC_STARTUP_US + `BVSC_SETTLE_US + `BVSC_BIST_US)
`define BVSC_DELAY_CYC          (`BVSC_DELAY_US * `BVSC_CLK_MHZ)
`define BVSC_CODE_SEG1          8'h0F
`define BVSC_CODE_SEG2          8'h73
`define BVSC_CODE_SEG3          8'hAB
`define BVSC_MV_BASE0           16'h012C
`define BVSC_MV_BASE1           16'h0258
`define BVSC_MV_BASE2           16'h044C
`define BVSC_MV_BASE3           16'h067C
`define BVSC_MV_STEP0           16'h0014
`define BVSC_MV_STEP1           16'h0005
`define BVSC_MV_STEP2           16'h000A
`define BVSC_MV_STEP3           16'h0014

`endif

// ===== hdl/bvsc_pkg.sv
// Types for the buck voltage select control block
package bvsc_pkg;
    typedef enum logic [1:0] {
        BVSC_MODE_PFM = 2'b00,
        BVSC_MODE_PWM = 2'b01
    } bvsc_mode_e;

    typedef enum logic [1:0] {
        BVSC_THR_IDLE = 2'b00,
        BVSC_THR_UP   = 2'b01,
        BVSC_THR_DOWN = 2'b10
    } bvsc_thr_e;

    typedef logic [7:0] bvsc_code_t;
    typedef logic [15:0] bvsc_mv_t;
endpackage

// ===== hdl/bvsc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module bvsc_sync (
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change accepted only once the last two stages agree
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end
endmodule

// ===== hdl/bvsc_delay.sv
// Down counter timing the delayed monitor threshold commit
`timescale 1ns/1ps
module bvsc_delay #(
    parameter int CYCLES = 12000
) (
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    input  wire logic load_in,
    input  wire logic abort_in,
    output logic      busy_out,
    output logic      expire_out
);
    logic [31:0] cnt_q;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 32'h0000_0000;
        end else if (abort_in) begin
            cnt_q <= 32'h0000_0000;
        end else if (load_in) begin
            cnt_q <= 32'(CYCLES);
        end else if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
        end
    end

    assign busy_out   = (cnt_q != 32'h0000_0000);
    assign expire_out = (cnt_q == 32'h0000_0001) && !load_in && !abort_in;
endmodule

// ===== bench/bvsc_top_tb_top.sv
// Directed self-checking testbench for the buck voltage select control block
`timescale 1ns/1ps
module bvsc_top_tb_top;
    localparam int DLY   = 20;
    localparam int LIMIT = 3000;

    logic                 clock_in = 1'b0;
    logic                 arst_n_in = 1'b0;
    logic                 heavy_load_in = 1'b0;
    logic                 forced_pwm_select_in = 1'b0;
    logic                 forced_multiphase_select_in = 1'b0;
    logic [3:0]           phase_request_in = 4'h0;
    logic [1:0]           nvm_ss_source_in = 2'h0;
    logic                 nvm_valid_in = 1'b0;
    logic                 ss_enable_in = 1'b0;
    logic [1:0]           ss_depth_in = 2'h0;
    logic                 sync_clock_input = 1'b0;
    logic                 setpoint_a_wr_in = 1'b0;
    logic                 setpoint_b_wr_in = 1'b0;
    logic [7:0]           setpoint_wdata_in = 8'h00;
    logic                 setpoint_choice_in = 1'b0;
    logic                 fault_recovery_state_in = 1'b0;
    logic                 warm_reset_in = 1'b0;
    logic                 low_power_standby_state_in = 1'b0;
    logic                 skip_standby_reload_in = 1'b0;
    bvsc_pkg::bvsc_mode_e mode_out;
    logic [3:0]           phase_active_out;
    logic [1:0]           ss_source_out;
    logic                 ss_active_out;
    logic [1:0]           ss_depth_out;
    logic                 sync_level_out;
    logic [7:0]           voltage_setpoint_a_out;
    logic [7:0]           voltage_setpoint_b_out;
    logic [7:0]           active_code_out;
    logic [15:0]          active_mv_out;
    logic [7:0]           ov_code_out;
    logic [7:0]           uv_code_out;
    logic                 thr_pending_out;
    int                   bad_count = 0;
    int                   total_checks = 0;
    int                   cycles = 0;
    logic [7:0]           codes [8] = '{8'h00, 8'h0E, 8'h0F, 8'h72, 8'h73, 8'hAA, 8'hAB, 8'hFF};

    bvsc_top #(.PHASES(4), .DELAY_CYC(DLY), .NVM_DEFAULT(8'h41)) i_bvsc_top (
        .clock_in, .arst_n_in, .heavy_load_in, .forced_pwm_select_in,
        .forced_multiphase_select_in, .phase_request_in, .nvm_ss_source_in, .nvm_valid_in,
        .ss_enable_in, .ss_depth_in, .sync_clock_input, .setpoint_a_wr_in, .setpoint_b_wr_in,
        .setpoint_wdata_in, .setpoint_choice_in, .fault_recovery_state_in, .warm_reset_in,
        .low_power_standby_state_in, .skip_standby_reload_in, .mode_out, .phase_active_out,
        .ss_source_out, .ss_active_out, .ss_depth_out, .sync_level_out, .voltage_setpoint_a_out,
        .voltage_setpoint_b_out, .active_code_out, .active_mv_out, .ov_code_out, .uv_code_out,
        .thr_pending_out
    );

    always #2.5 clock_in = ~clock_in;

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Leaves the caller just after an edge so outputs are settled
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clock_in);
        arst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        tick(1);
    endtask

    // The write is taken at the second edge; active level follows one edge later if that register is selected
    task automatic write_sp(input logic sel_b, input logic [7:0] code);
        @(posedge clock_in);
        setpoint_a_wr_in <= !sel_b;
        setpoint_b_wr_in <= sel_b;
        setpoint_wdata_in <= code;
        @(posedge clock_in);
        setpoint_a_wr_in <= 1'b0;
        setpoint_b_wr_in <= 1'b0;
    endtask

    // Expected millivolts worked out from the four linear code segments
    function automatic logic [15:0] mv_of(input logic [7:0] c);
        if (c < 8'h0F) return 16'h012C + 16'(c) * 16'h0014;
        if (c < 8'h73) return 16'h0258 + 16'(c - 8'h0F) * 16'h0005;
        if (c < 8'hAB) return 16'h044C + 16'(c - 8'h73) * 16'h000A;
        return 16'h067C + 16'(c - 8'hAB) * 16'h0014;
    endfunction

    initial begin
        do_reset();
        check(16'(ss_active_out), 16'h0000);
        check(16'(active_code_out), 16'h0041);
        check(active_mv_out, 16'h0352);
        check(16'(voltage_setpoint_a_out), 16'h0041);
        for (int s = 0; s < 3; s++) begin
            do_reset();
            nvm_ss_source_in <= 2'(s);
            nvm_valid_in <= 1'b1;
            tick(3);
            check(16'(ss_source_out), 16'(s));
            nvm_ss_source_in <= 2'(s + 1);
            tick(3);
            check(16'(ss_source_out), 16'(s));
        end
        // Load-driven and forced mode choice and phase handling
        heavy_load_in <= 1'b1;
        phase_request_in <= 4'h6;
        tick(4);
        check(16'(mode_out), 16'h0001);
        check(16'(phase_active_out), 16'h0007);
        heavy_load_in <= 1'b0;
        tick(4);
        check(16'(mode_out), 16'h0000);
        forced_pwm_select_in <= 1'b1;
        tick(4);
        check(16'(mode_out), 16'h0001);
        forced_pwm_select_in <= 1'b0;
        forced_multiphase_select_in <= 1'b1;
        tick(4);
        check(16'(mode_out), 16'h0001);
        check(16'(phase_active_out), 16'h000F);
        forced_multiphase_select_in <= 1'b0;
        // Spread enable and depth guard
        ss_enable_in <= 1'b1;
        ss_depth_in <= 2'h3;
        tick(4);
        check(16'(ss_active_out), 16'h0001);
        check(16'(ss_depth_out), 16'h0000);
        ss_enable_in <= 1'b0;
        ss_depth_in <= 2'h2;
        tick(4);
        check(16'(ss_active_out), 16'h0000);
        check(16'(ss_depth_out), 16'h0002);
        ss_enable_in <= 1'b1;
        sync_clock_input <= 1'b1;
        tick(6);
        check(16'(sync_level_out), 16'h0001);
        // Rising step: over-voltage now, under-voltage after the delay
        write_sp(1'b0, 8'h73);
        tick(1);
        check(16'(active_code_out), 16'h0073);
        check(16'(ov_code_out), 16'h0073);
        check(16'(uv_code_out), 16'h0041);
        check(16'(thr_pending_out), 16'h0001);
        tick(DLY - 1);
        check(16'(uv_code_out), 16'h0041);
        tick(1);
        check(16'(uv_code_out), 16'h0073);
        check(16'(thr_pending_out), 16'h0000);
        // Falling step through the other setpoint
        write_sp(1'b1, 8'h0F);
        tick(2);
        check(16'(active_code_out), 16'h0073);
        check(16'(voltage_setpoint_b_out), 16'h000F);
        setpoint_choice_in <= 1'b1;
        tick(2);
        check(16'(active_code_out), 16'h000F);
        check(16'(uv_code_out), 16'h000F);
        check(16'(ov_code_out), 16'h0073);
        tick(DLY);
        check(16'(ov_code_out), 16'h000F);
        // Back-to-back code changes restart the delay each time
        foreach (codes[i]) begin
            write_sp(1'b1, codes[i]);
            tick(1);
            check(active_mv_out, mv_of(codes[i]));
        end
        tick(DLY + 2);
        check(16'(ov_code_out), 16'h00FF);
        check(16'(uv_code_out), 16'h00FF);
        setpoint_choice_in <= 1'b0;
        tick(DLY + 4);
        // Reverting events; the last one is standby with reload skipped
        for (int e = 0; e < 4; e++) begin
            write_sp(1'b0, 8'h80);
            tick(2);
            skip_standby_reload_in <= (e == 3);
            fault_recovery_state_in <= (e == 0);
            warm_reset_in <= (e == 1);
            low_power_standby_state_in <= (e >= 2);
            tick(2);
            fault_recovery_state_in <= 1'b0;
            warm_reset_in <= 1'b0;
            low_power_standby_state_in <= 1'b0;
            tick(4);
            check(16'(active_code_out), (e == 3) ? 16'h0080 : 16'h0041);
            check(16'(ss_active_out), 16'h0001);
            tick(DLY + 2);
        end
        report_and_stop();
    end
endmodule
